// File: src/mci_pkg.sv
// Purpose: Constants for the motion card interrupt unit
// Assumes: 40 MHz core clock, two axes
// Notes:   Mask bit positions and error code values
package mci_pkg;
    localparam int          MCI_AXES       = 2;
    localparam int          MCI_MOT_W      = 32;
    localparam int          MCI_GPI_W      = 16;
    localparam int          MCI_ERR_W      = 18;
    localparam int          MCI_CODE_W     = 5;
    // Motion mask: bits 3, 17, 18, 20..31 unused
    localparam logic [31:0] MCI_MOT_USED   = 32'h0009_FFF7;
    // General-purpose mask: bits 11..14 unused
    localparam logic [15:0] MCI_GPI_USED   = 16'h87FF;
    localparam int          MCI_GPI_FALL0  = 0;
    localparam int          MCI_GPI_RISE0  = 4;
    localparam int          MCI_GPI_MF0    = 8;
    localparam int          MCI_GPI_MODE   = 10;
    localparam int          MCI_GPI_MASTER = 15;
    // Error codes by cause
    localparam logic [4:0]  MCI_E_PSOFT    = 5'h00;
    localparam logic [4:0]  MCI_E_NSOFT    = 5'h01;
    localparam logic [4:0]  MCI_E_CMP3     = 5'h02;
    localparam logic [4:0]  MCI_E_CMP4     = 5'h03;
    localparam logic [4:0]  MCI_E_CMP5     = 5'h04;
    localparam logic [4:0]  MCI_E_PEND     = 5'h05;
    localparam logic [4:0]  MCI_E_NEND     = 5'h06;
    localparam logic [4:0]  MCI_E_ALARM    = 5'h07;
    localparam logic [4:0]  MCI_E_STOPALL  = 5'h08;
    localparam logic [4:0]  MCI_E_EMERG    = 5'h09;
    localparam logic [4:0]  MCI_E_SLOW     = 5'h0A;
    localparam logic [4:0]  MCI_E_INTERP   = 5'h0C;
    localparam logic [4:0]  MCI_E_OTHER    = 5'h0D;
    localparam logic [4:0]  MCI_E_PBUF     = 5'h0E;
    localparam logic [4:0]  MCI_E_ICNT     = 5'h0F;
    localparam logic [4:0]  MCI_E_ENC      = 5'h10;
    localparam logic [4:0]  MCI_E_PIN      = 5'h11;
    localparam logic [31:0] MCI_MOT_RST    = 32'h0000_0000;
    localparam logic [15:0] MCI_GPI_RST    = 16'h0000;
    // Edges after reset release before pin history is trusted
    localparam logic [1:0]  MCI_PIN_SETTLE = 2'h3;
    // Error causes that stop the axis; index 11 is unassigned
    localparam logic [15:0] MCI_ERR_STOP   = 16'hF7FF;
endpackage : mci_pkg

// File: src/mci_unit.sv
// Purpose: Interrupt collection for a two-axis motion card
// Assumes: Event inputs are one-cycle pulses in sys_clk domain;
//          card digital and multifunction pins are asynchronous
// Notes:   Error cause index i maps to error code table entry i
//
// Contract
// - Three groups; errors never maskable
// - One host request, card enable gates all
// - Motion bits 0-2, 4-7 stop/buffer/accel events
// - Motion bits 8-12 comparators one to five
// - Bits 13-15 counter clear and latch events
// - Bit 16 slowdown, 19 start, others zero
// - Error cause reported as numeric code
// - Codes 0-4 soft limits and comparators
// - Codes 5-7 end limits and alarm
// - Codes 8-10 stop-all, emergency, slowdown
// - Codes 12-15 interpolation, propagation, overflows
// - Codes 16-17 signal errors, axis keeps moving
// - GP mask: falling bits 0-3, rising 4-7
// - GP bits 8-9 multifunction pins, 10 edge
// - GP bit 15 master switch, 11-14 zero
module mci_unit
    import mci_pkg::*;
#(
    parameter int AXES = MCI_AXES
) (
    input  wire logic                          sys_clk,
    input  wire logic                          arst_n,
    input  wire logic                          int_enable,
    input  wire logic [AXES-1:0][MCI_MOT_W-1:0] motion_mask,
    input  wire logic [MCI_GPI_W-1:0]          gpio_mask,
    input  wire logic [AXES-1:0][MCI_MOT_W-1:0] motion_event,
    input  wire logic [AXES-1:0][MCI_ERR_W-1:0] error_event,
    input  wire logic                          digital_input_zero,
    input  wire logic                          digital_input_one,
    input  wire logic                          digital_input_two,
    input  wire logic                          digital_input_three,
    input  wire logic                          first_multifunction_pin,
    input  wire logic                          second_multifunction_pin,
    input  wire logic [AXES-1:0][MCI_MOT_W-1:0] motion_ack,
    input  wire logic [MCI_GPI_W-1:0]          gpio_ack,
    input  wire logic [AXES-1:0]               error_ack,
    output logic                               host_irq,
    output logic      [AXES-1:0][MCI_MOT_W-1:0] motion_pending,
    output logic      [MCI_GPI_W-1:0]          gpio_pending,
    output logic      [AXES-1:0]               error_valid,
    output logic      [AXES-1:0][MCI_CODE_W-1:0] error_code,
    output logic      [AXES-1:0]               axis_stop
);

    typedef logic [MCI_CODE_W-1:0] mci_code_type;

    // Error cause index to code; index 11 is unassigned
    function automatic mci_code_type mci_code_of(input int idx);
        case (idx)
            0:       mci_code_of = MCI_E_PSOFT;
            1:       mci_code_of = MCI_E_NSOFT;
            2:       mci_code_of = MCI_E_CMP3;
            3:       mci_code_of = MCI_E_CMP4;
            4:       mci_code_of = MCI_E_CMP5;
            5:       mci_code_of = MCI_E_PEND;
            6:       mci_code_of = MCI_E_NEND;
            7:       mci_code_of = MCI_E_ALARM;
            8:       mci_code_of = MCI_E_STOPALL;
            9:       mci_code_of = MCI_E_EMERG;
            10:      mci_code_of = MCI_E_SLOW;
            12:      mci_code_of = MCI_E_INTERP;
            13:      mci_code_of = MCI_E_OTHER;
            14:      mci_code_of = MCI_E_PBUF;
            15:      mci_code_of = MCI_E_ICNT;
            16:      mci_code_of = MCI_E_ENC;
            17:      mci_code_of = MCI_E_PIN;
            default: mci_code_of = MCI_E_PSOFT;
        endcase
    endfunction : mci_code_of

    // Lowest index wins when several causes arrive together
    function automatic int mci_first(input logic [MCI_ERR_W-1:0] v);
        mci_first = 0;
        for (int i = MCI_ERR_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                mci_first = i;
            end
        end
    endfunction : mci_first

    // Pin synchronisers: 6 pins, two stages
    logic [5:0] pin_s1_r;
    logic [5:0] pin_s2_r;
    logic [5:0] pin_d_r;
    wire  [5:0] pin_raw = {second_multifunction_pin,
                           first_multifunction_pin,
                           digital_input_three, digital_input_two,
                           digital_input_one, digital_input_zero};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_r <= 6'h00;
            pin_s2_r <= 6'h00;
            pin_d_r  <= 6'h00;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pin_d_r  <= pin_s2_r;
        end
    end

    // Reset history is not the pin level; hide edges until it is
    logic [1:0] pin_age_r;
    wire        pin_ok  = (pin_age_r == MCI_PIN_SETTLE);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_age_r <= 2'h0;
        end else if (!pin_ok) begin
            pin_age_r <= pin_age_r + 2'h1;
        end
    end

    wire [5:0] pin_fall = pin_d_r & ~pin_s2_r & {6{pin_ok}};
    wire [5:0] pin_rise = ~pin_d_r & pin_s2_r & {6{pin_ok}};
    wire       mf_rise  = gpio_mask[MCI_GPI_MODE];
    wire [1:0] mf_edge  = mf_rise ? pin_rise[5:4] : pin_fall[5:4];

    // General-purpose event vector in mask bit order
    logic [MCI_GPI_W-1:0] gpio_event;
    always_comb begin
        gpio_event = '0;
        gpio_event[MCI_GPI_FALL0 +: 4] = pin_fall[3:0];
        gpio_event[MCI_GPI_RISE0 +: 4] = pin_rise[3:0];
        gpio_event[MCI_GPI_MF0 +: 2]   = mf_edge;
    end

    // Master switch must be set for any GP source to count
    wire gpio_on = gpio_mask[MCI_GPI_MASTER];
    wire [MCI_GPI_W-1:0] gpio_set =
        gpio_event & gpio_mask & MCI_GPI_USED &
        {MCI_GPI_W{gpio_on}};

    logic [MCI_GPI_W-1:0] gpio_pend_r;
    wire  [MCI_GPI_W-1:0] gpio_pend_nxt =
        gpio_set | (gpio_pend_r & ~gpio_ack);
    wire  [MCI_GPI_W-1:0] gpio_live =
        gpio_pend_r & {MCI_GPI_W{gpio_on}};

    // Motion and error pending per axis
    logic [AXES-1:0][MCI_MOT_W-1:0]  mot_pend_r;
    logic [AXES-1:0][MCI_MOT_W-1:0]  mot_pend_nxt;
    logic [AXES-1:0][MCI_MOT_W-1:0]  mot_set;
    logic [AXES-1:0]                 err_val_r;
    logic [AXES-1:0]                 err_val_nxt;
    logic [AXES-1:0][MCI_CODE_W-1:0] err_code_r;
    logic [AXES-1:0][MCI_CODE_W-1:0] err_code_nxt;
    logic [AXES-1:0]                 stop_nxt;
    logic [AXES-1:0]                 mot_any;

    always_comb begin
        for (int a = 0; a < AXES; a++) begin
            // Unused positions can never pend
            mot_set[a] = motion_event[a] & motion_mask[a]
                         & MCI_MOT_USED;
            // A new event beats a same-cycle acknowledge
            mot_pend_nxt[a] = mot_set[a]
                              | (mot_pend_r[a] & ~motion_ack[a]);
            mot_any[a] = |mot_pend_r[a];
            // Errors have no mask; newest cause overwrites
            if (|error_event[a]) begin
                err_val_nxt[a]  = 1'b1;
                err_code_nxt[a] = mci_code_of(mci_first(error_event[a]));
            end else begin
                err_val_nxt[a]  = err_val_r[a] & ~error_ack[a];
                err_code_nxt[a] = err_code_r[a];
            end
            // Signal errors report without stopping the axis
            stop_nxt[a] = |(error_event[a][15:0] & MCI_ERR_STOP);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gpio_pend_r <= MCI_GPI_RST;
            mot_pend_r  <= '0;
            err_val_r   <= '0;
            err_code_r  <= '0;
            axis_stop   <= '0;
        end else begin
            gpio_pend_r <= gpio_pend_nxt;
            mot_pend_r  <= mot_pend_nxt;
            err_val_r   <= err_val_nxt;
            err_code_r  <= err_code_nxt;
            axis_stop   <= stop_nxt;
        end
    end

    // Pending state is kept while disabled; only the request is gated
    wire irq_nxt = int_enable &
                   ((|mot_any) | (|gpio_live) | (|err_val_r));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            host_irq <= 1'b0;
        end else begin
            host_irq <= irq_nxt;
        end
    end

    assign motion_pending = mot_pend_r;
    assign gpio_pending   = gpio_pend_r;
    assign error_valid    = err_val_r;
    assign error_code     = err_code_r;

endmodule : mci_unit

// File: verif/mci_host_model.sv
// Purpose: Host-side model that enables and then programs the unit
// Assumes: Requests arrive from the bench as levels
// Notes:   Masks load only once the enable is seen high
module mci_host_model
    import mci_pkg::*;
(
    input  wire logic                                sys_clk,
    input  wire logic                                arst_n,
    input  wire logic                                req_en,
    input  wire logic [MCI_AXES-1:0][MCI_MOT_W-1:0] req_mm,
    input  wire logic [MCI_GPI_W-1:0]                req_gm,
    output logic                                     int_enable,
    output logic      [MCI_AXES-1:0][MCI_MOT_W-1:0] motion_mask,
    output logic      [MCI_GPI_W-1:0]                gpio_mask
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            int_enable  <= 1'b0;
            motion_mask <= '0;
            gpio_mask   <= '0;
        end else begin
            int_enable <= req_en;
            // Masks never change ahead of the enable
            if (int_enable) begin
                motion_mask <= req_mm;
                gpio_mask   <= req_gm | 16'h8000;
            end
        end
    end
endmodule : mci_host_model

// File: verif/mci_unit_asserts.sv
// Purpose: Port-level checks for the motion card interrupt unit
// Assumes: Axis 0 carries the sampled relations
// Notes:   Bound onto every mci_unit instance
module mci_unit_asserts
    import mci_pkg::*;
#(
    parameter int AXES = MCI_AXES
) (
    input wire logic                             sys_clk,
    input wire logic                             arst_n,
    input wire logic                             int_enable,
    input wire logic [AXES-1:0][MCI_MOT_W-1:0]  motion_mask,
    input wire logic [AXES-1:0][MCI_MOT_W-1:0]  motion_event,
    input wire logic [AXES-1:0][MCI_ERR_W-1:0]  error_event,
    input wire logic [AXES-1:0][MCI_MOT_W-1:0]  motion_ack,
    input wire logic [AXES-1:0]                 error_ack,
    input wire logic                             host_irq,
    input wire logic [AXES-1:0][MCI_MOT_W-1:0]  motion_pending,
    input wire logic [MCI_GPI_W-1:0]             gpio_pending,
    input wire logic [AXES-1:0]                 error_valid,
    input wire logic [AXES-1:0][MCI_CODE_W-1:0] error_code,
    input wire logic [AXES-1:0]                 axis_stop
);
    logic [31:0] hit0;
    assign hit0 = motion_event[0] & motion_mask[0] & MCI_MOT_USED;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence ev_s; motion_event[0][0] && motion_mask[0][0]; endsequence
    sequence ack_s; motion_ack[0][0] && !motion_event[0][0]; endsequence
    mot_set_a: assert property (hit0 != 0 |=>
        (motion_pending[0] & $past(hit0)) == $past(hit0))
        else $error("enabled motion event not pending");
    mot_mask_a: assert property (1'b1 |=> (motion_pending[0] &
        ~$past(motion_pending[0]) & ~$past(hit0)) == 0)
        else $error("motion pending set without enabled event");
    unused_zero_a: assert property (
        (motion_pending[0] & ~MCI_MOT_USED) == 0 &&
        (gpio_pending & ~MCI_GPI_USED) == 0) else $error("unused bit pending");
    irq_walk_a: assert property (ev_s ##1 int_enable |=> host_irq)
        else $error("request missing two cycles after event");
    irq_off_a: assert property (!int_enable |=> !host_irq)
        else $error("request raised while disabled");
    mot_clr_a: assert property (ack_s |=> !motion_pending[0][0])
        else $error("motion pending survived acknowledge");
    err_code_a: assert property (error_event[0] == 18'h00200 |=>
        error_valid[0] && error_code[0] == MCI_E_EMERG)
        else $error("emergency stop code wrong");
    stop_pulse_a: assert property (1'b1 |=> axis_stop[0] ==
        $past(|(error_event[0] & 18'h0F7FF))) else $error("axis stop wrong");
    err_clr_a: assert property (error_ack[0] && !error_event[0] |=>
        !error_valid[0]) else $error("error valid survived acknowledge");
endmodule : mci_unit_asserts
bind mci_unit mci_unit_asserts #(.AXES(AXES)) u_chk (.*);

// File: verif/mci_unit_tb.sv
// Purpose: Self-checking bench for the motion card interrupt unit
// Assumes: Host model programs enable and masks
// Notes:   Pins two, three and second pin stay idle
module mci_unit_tb;
    import mci_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0, arst_n = 1'b0, req_en = 1'b0;
    logic [15:0] req_gm = '0, gpio_ack = '0;
    logic [1:0][31:0] req_mm = '0, motion_event = '0, motion_ack = '0;
    logic [1:0][17:0] error_event = '0;
    logic [1:0] error_ack = '0;
    logic digital_input_zero = 1'b1, digital_input_one = 1'b1;
    logic digital_input_two = 1'b1, digital_input_three = 1'b1;
    logic first_multifunction_pin = 1'b0, second_multifunction_pin = 1'b0;
    wire logic int_enable, host_irq;
    wire logic [1:0][31:0] motion_mask, motion_pending;
    wire logic [15:0] gpio_mask, gpio_pending;
    wire logic [1:0] error_valid, axis_stop;
    wire logic [1:0][4:0] error_code;
    int err_total = 0, n_tests = 0;
    always #12.5 sys_clk = ~sys_clk;
    mci_unit dut (.*);
    mci_host_model host (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tk(input int n = 1);
        repeat (n) @(posedge sys_clk);
    endtask : tk
    task complete_run;
        if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        tk(2);
        arst_n <= 1'b1;
        req_en <= 1'b1;
        req_mm[0] <= '1;
        req_gm <= 16'h8501;
        tk(4);
        motion_event <= '1;
        tk;
        motion_event <= '0;
        #1 chk(motion_pending[0], MCI_MOT_USED);
        chk(motion_pending[1], 32'h0);
        tk;
        #1 chk(32'(host_irq), 32'h1);
        tk;
        motion_ack[0] <= '1;
        req_en <= 1'b0;
        tk;
        motion_ack <= '0;
        motion_event[0] <= 32'h1;
        #1 chk(motion_pending[0], 32'h0);
        tk;
        motion_event <= '0;
        tk(2);
        #1 chk(32'(host_irq), 32'h0);
        chk(motion_pending[0], 32'h1);
        tk;
        req_en <= 1'b1;
        tk(3);
        #1 chk(32'(host_irq), 32'h1);
        tk;
        motion_ack[0] <= 32'h1;
        for (int a = 0; a < 2; a++)
        for (int i = 0; i < 18; i++)
        if (i != 11) begin
            tk;
            motion_ack <= '0;
            error_event[a] <= 18'h1 << i;
            tk;
            error_event <= '0;
            #1 chk(32'({error_valid[a], error_code[a], axis_stop[a]}),
                32'({1'b1, 5'(i), i < 16}));
            tk;
            error_ack[a] <= 1'b1;
            #1 chk(32'(host_irq), 32'h1);
            tk;
            error_ack <= '0;
            #1 chk(32'(error_valid[a]), 32'h0);
        end
        tk;
        digital_input_zero <= 1'b0;
        digital_input_one <= 1'b0;
        first_multifunction_pin <= 1'b1;
        tk(7);
        #1 chk({host_irq, gpio_pending}, 17'h10101);
        tk;
        gpio_ack <= '1;
        tk;
        gpio_ack <= '0;
        #1 chk(32'(gpio_pending), 32'h0);
        complete_run;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        err_total++;
        complete_run;
    end
endmodule : mci_unit_tb
